// file: design/analog_channel_cfg.svh
`ifndef ANALOG_CHANNEL_CFG_SVH
`define ANALOG_CHANNEL_CFG_SVH

`define ACC_NUM_CHAN 128

// Register byte offsets
`define ACC_REG_SEL 8'h00
`define ACC_REG_INST 8'h04
`define ACC_REG_CFG 8'h08
`define ACC_REG_MODE 8'h0c
`define ACC_REG_ENABLE 8'h10
`define ACC_REG_RANGE 8'h14
`define ACC_REG_FILTER 8'h18
`define ACC_REG_STATUS 8'h1c
`define ACC_REG_WARN 8'h20
`define ACC_REG_ERROR 8'h24
`define ACC_REG_READ 8'h28
`define ACC_REG_SCAN 8'h2c
`define ACC_REG_READING 8'h30

// Field positions
`define ACC_CFG_MODE 3:0
`define ACC_CFG_RANGE 7:4
`define ACC_CFG_ENABLE 15:8
`define ACC_CFG_FILTER 31:16
`define ACC_SCAN_FIRST 6:0
`define ACC_SCAN_LAST 14:8
`define ACC_SCAN_SETS 23:16
`define ACC_SCAN_ASYNC 24
`define ACC_INST_LO 6:0
`define ACC_INST_HI 14:8

// Encodings and reset values
`define ACC_MODE_SINGLE 2'h1
`define ACC_MODE_DIFF 2'h2
`define ACC_RANGE_10V 3'h1
`define ACC_RANGE_1V 3'h2
`define ACC_RANGE_65MA 3'h3
`define ACC_RANGE_4_20 3'h4
`define ACC_FILTER_MAX 16'h00ff
`define ACC_INST_LO_RST 7'h00
`define ACC_INST_HI_RST 7'h7f

// Warning bit positions
`define ACC_WARN_DIFF 0
`define ACC_WARN_10V 1
`define ACC_WARN_TRUNC 2
`define ACC_WARN_SKIP 3

// Error codes
`define ACC_ERR_NOT_INSTALLED 16'h05e1
`define ACC_ERR_BAD_CHAN 16'h05e2
`define ACC_ERR_BAD_MODE 16'h05e5
`define ACC_ERR_BAD_RANGE 16'h05e6
`define ACC_ERR_BAD_FILTER 16'h05e7
`define ACC_ERR_FIRST_LAST 16'h05ef

// 4-20 mA to percent (0.01 % units): zero offset, scale/2^13, full span
`define ACC_PCT_OFFSET 32'sh00000790
`define ACC_PCT_SCALE 32'sh00002955
`define ACC_PCT_SHIFT 13
`define ACC_PCT_FULL 32'sh00002710

`endif

// file: design/analog_channel_pkg.sv
package analog_channel_pkg;

  typedef enum logic [1:0] {SCAN_IDLE, SCAN_ISSUE, SCAN_WAIT} scan_state_e;

  typedef logic [1:0] mode_t;
  typedef logic [2:0] range_t;
  typedef logic [2:0] flog_t;

endpackage

// file: design/analog_channel_config.sv
// What this block does
// - Channel index must be 0..127; anything else gives the illegal-channel error.
// - One combined write sets mode, enable, range and filter together.
// - Mode 1 single-ended, 2 differential; other values give error 1509.
// - A current range forces differential mode; warn 1507 if it was single-ended.
// - Even channel in differential mode pairs with the next higher channel.
// - Odd channel in differential mode pairs with the next lower channel.
// - A mode-only write from differential to single-ended on a current range gives 10V range, warning 1524.
// - Enable 0 means skip; any non-zero enable means read.
// - Skipped channels are left out of block scans.
// - Single read of a skipped channel gives a warning, not an error.
// - Asynchronous scanning never visits skipped channels.
// - Range 1 10V, 2 1V, 3 65mA, 4 4-20mA; others give error 1510.
// - The 4-20 mA range reports readings as percent of span.
// - Filter sets how many readings the running average spans.
// - Filter 0..255 accepted, 0 and 1 mean one reading; above gives 1511.
// - Filter neither zero nor power of two is truncated, warning 1515.
// - Truncation picks the largest power of two not above the value.
// - After a filter change the result is invalid until enough readings.
// - Status gives mode 1..2, range 1..4, filter length 1..128.
// - Status gives enable as 0 or 1 only.
// - Channel beyond installed range gives 1505; beyond legal range gives 1506.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "analog_channel_cfg.svh"

module analog_channel_config
  import analog_channel_pkg::*;
#(
  parameter int NUM_CHAN = `ACC_NUM_CHAN
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SAMPLE_VALID,
  input wire logic [15:0] SAMPLE_DATA,
  output logic CONV_REQ,
  output logic [6:0] CONV_CHAN,
  output logic [6:0] CONV_LOW_CHAN,
  output logic CONV_DIFF,
  output logic [2:0] CONV_RANGE,
  output logic READING_VALID,
  output logic [6:0] READING_CHAN,
  output logic [15:0] READING
);

  if (NUM_CHAN < 2 || NUM_CHAN > 128 || (NUM_CHAN % 2) != 0)
  begin : g_bad_param
    $error("NUM_CHAN must be even and within 2..128");
  end

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] sel;
    logic [6:0] inst_lo;
    logic [6:0] inst_hi;
    logic [NUM_CHAN-1:0][1:0] mode;
    logic [NUM_CHAN-1:0] en;
    logic [NUM_CHAN-1:0][2:0] rng;
    logic [NUM_CHAN-1:0][2:0] flog;
    logic [NUM_CHAN-1:0][23:0] acc;
    logic [NUM_CHAN-1:0][7:0] cnt;
    logic [NUM_CHAN-1:0] fvalid;
    logic [3:0] warn;
    logic [15:0] err;
    scan_state_e st;
    logic [7:0] cur;
    logic [6:0] first;
    logic [6:0] last;
    logic [7:0] sets;
    logic async_mode;
    logic conv_req;
    logic [6:0] conv_chan;
    logic [6:0] conv_low;
    logic conv_diff;
    logic [2:0] conv_range;
    logic rd_valid;
    logic [6:0] rd_chan;
    logic [15:0] rd_data;
  } state_s;

  state_s r;
  state_s n;

  function automatic logic [15:0] chan_err(input logic [15:0] c, input logic [6:0] lo,
                                           input logic [6:0] hi);
    if (c >= 16'(NUM_CHAN))
      return `ACC_ERR_BAD_CHAN;
    if (c[6:0] < lo || c[6:0] > hi)
      return `ACC_ERR_NOT_INSTALLED;
    return 16'h0000;
  endfunction

  function automatic logic is_current(input range_t rg);
    return rg == `ACC_RANGE_65MA || rg == `ACC_RANGE_4_20;
  endfunction

  // Index of the highest set bit of a value no larger than 255
  function automatic flog_t floor_log2(input logic [15:0] v);
    flog_t k;
    k = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (v[i])
        k = 3'(i);
    end
    return k;
  endfunction

  // First enabled channel in [from, hi]; bit 7 set means none
  function automatic logic [7:0] find_enabled(input logic [NUM_CHAN-1:0] e,
                                              input logic [7:0] from, input logic [6:0] hi);
    logic [7:0] f;
    f = 8'h80;
    for (int i = NUM_CHAN - 1; i >= 0; i--)
    begin
      if (e[i] && 8'(i) >= from && 7'(i) <= hi)
        f = 8'(i);
    end
    return f;
  endfunction

  always_comb
  begin
    logic setup;
    logic access;
    logic hit;
    logic do_mode;
    logic do_en;
    logic do_rng;
    logic do_flt;
    logic [15:0] wm;
    logic [15:0] wr;
    logic [15:0] wf;
    logic [31:0] we;
    logic [15:0] ce;
    logic bad;
    logic [6:0] c;
    mode_t nm;
    range_t nr;
    flog_t k;
    logic [7:0] nlen;
    logic [7:0] cn;
    logic [7:0] f;
    logic [6:0] hi;
    logic signed [31:0] d;
    logic signed [31:0] p;
    logic signed [23:0] xs;
    logic signed [23:0] a;
    setup = 1'b0;
    access = 1'b0;
    hit = 1'b0;
    do_mode = 1'b0;
    do_en = 1'b0;
    do_rng = 1'b0;
    do_flt = 1'b0;
    wm = 16'h0000;
    wr = 16'h0000;
    wf = 16'h0000;
    we = 32'h00000000;
    ce = 16'h0000;
    bad = 1'b0;
    c = 7'h00;
    nm = 2'h0;
    nr = 3'h0;
    k = 3'h0;
    nlen = 8'h00;
    cn = 8'h00;
    f = 8'h00;
    hi = 7'h00;
    d = 32'sh0;
    p = 32'sh0;
    xs = 24'sh0;
    a = 24'sh0;
    n = r;
    n.conv_req = 1'b0;
    n.rd_valid = 1'b0;

    // Bus: read data and error are prepared in the setup cycle so they leave flops
    setup = PSEL && !PENABLE;
    access = PSEL && PENABLE && r.pready;
    n.pready = setup;
    ce = chan_err(r.sel, r.inst_lo, r.inst_hi);
    c = r.sel[6:0];
    if (setup)
    begin
      hit = 1'b1;
      n.prdata = 32'h00000000;
      unique case (PADDR)
        `ACC_REG_SEL: n.prdata = {16'h0000, r.sel};
        `ACC_REG_INST: n.prdata = {17'h00000, r.inst_hi, 1'b0, r.inst_lo};
        `ACC_REG_STATUS:
          if (ce == 16'h0000)
            n.prdata = {8'h00, 8'h01 << r.flog[c], 5'h00, r.rng[c], 3'h0, r.en[c],
                        2'h0, r.mode[c]};
        `ACC_REG_WARN: n.prdata = {28'h0000000, r.warn};
        `ACC_REG_ERROR: n.prdata = {16'h0000, r.err};
        `ACC_REG_SCAN: n.prdata = {6'h00, r.st != SCAN_IDLE, r.async_mode, r.sets,
                                   1'b0, r.last, 1'b0, r.first};
        `ACC_REG_READING:
          if (ce == 16'h0000)
            n.prdata = {r.fvalid[c], 15'h0000, r.acc[c][15:0]};
        `ACC_REG_CFG, `ACC_REG_MODE, `ACC_REG_ENABLE, `ACC_REG_RANGE,
        `ACC_REG_FILTER, `ACC_REG_READ: n.prdata = 32'h00000000;
        default: hit = 1'b0;
      endcase
      n.pslverr = !hit;
    end

    // Conversion sequencer; skipped channels are never requested
    unique case (r.st)
      SCAN_IDLE: ;
      SCAN_ISSUE:
      begin
        hi = r.async_mode ? 7'(NUM_CHAN - 1) : r.last;
        f = find_enabled(r.en, r.cur, hi);
        if (!f[7])
        begin
          n.conv_req = 1'b1;
          n.conv_chan = f[6:0];
          n.conv_low = f[6:0] ^ 7'h01;
          n.conv_diff = r.mode[f[6:0]] == `ACC_MODE_DIFF;
          n.conv_range = r.rng[f[6:0]];
          n.st = SCAN_WAIT;
        end
        else if (r.async_mode)
          n.cur = 8'h00;
        else if (r.sets > 8'h01)
        begin
          n.sets = r.sets - 8'h01;
          n.cur = {1'b0, r.first};
        end
        else
        begin
          n.sets = 8'h00;
          n.st = SCAN_IDLE;
        end
      end
      SCAN_WAIT:
        if (SAMPLE_VALID)
        begin
          c = r.conv_chan;
          xs = 24'($signed(SAMPLE_DATA));
          if (r.rng[c] == `ACC_RANGE_4_20)
          begin
            d = 32'($signed(SAMPLE_DATA)) - `ACC_PCT_OFFSET;
            p = (d * `ACC_PCT_SCALE) >>> `ACC_PCT_SHIFT;
            if (d < 0)
              p = 32'sh0;
            if (p > `ACC_PCT_FULL)
              p = `ACC_PCT_FULL;
            xs = 24'(p);
          end
          k = r.flog[c];
          nlen = 8'h01 << k;
          a = $signed(r.acc[c]);
          if (r.cnt[c] < nlen)
          begin
            // Warm-up sums the first readings so no stale value is reported
            a = a + xs;
            cn = r.cnt[c] + 8'h01;
            n.cnt[c] = cn;
            if (cn == nlen)
            begin
              a = a >>> k;
              n.fvalid[c] = 1'b1;
            end
          end
          else
            a = a + ((xs - a) >>> k);
          n.acc[c] = a;
          if (n.fvalid[c])
          begin
            n.rd_valid = 1'b1;
            n.rd_chan = c;
            n.rd_data = a[15:0];
          end
          n.cur = {1'b0, c} + 8'h01;
          n.st = SCAN_ISSUE;
        end
      default: n.st = SCAN_IDLE;
    endcase

    // Register writes and the side effects of status reads
    c = r.sel[6:0];
    if (access && !r.pslverr)
    begin
      if (!PWRITE && PADDR == `ACC_REG_STATUS && ce != 16'h0000)
        n.err = ce;
      if (PWRITE)
      begin
        unique case (PADDR)
          `ACC_REG_SEL: n.sel = PWDATA[15:0];
          `ACC_REG_INST:
          begin
            n.inst_lo = PWDATA[`ACC_INST_LO];
            n.inst_hi = PWDATA[`ACC_INST_HI];
          end
          `ACC_REG_CFG:
          begin
            // Combined write goes through the same path as the four single ones
            do_mode = 1'b1;
            do_en = 1'b1;
            do_rng = 1'b1;
            do_flt = 1'b1;
            wm = {12'h000, PWDATA[`ACC_CFG_MODE]};
            wr = {12'h000, PWDATA[`ACC_CFG_RANGE]};
            we = {24'h000000, PWDATA[`ACC_CFG_ENABLE]};
            wf = PWDATA[`ACC_CFG_FILTER];
          end
          `ACC_REG_MODE:
          begin
            do_mode = 1'b1;
            wm = PWDATA[15:0];
          end
          `ACC_REG_ENABLE:
          begin
            do_en = 1'b1;
            we = PWDATA;
          end
          `ACC_REG_RANGE:
          begin
            do_rng = 1'b1;
            wr = PWDATA[15:0];
          end
          `ACC_REG_FILTER:
          begin
            do_flt = 1'b1;
            wf = PWDATA[15:0];
          end
          `ACC_REG_WARN: n.warn = r.warn & ~PWDATA[3:0];
          `ACC_REG_ERROR: n.err = 16'h0000;
          `ACC_REG_READ:
            if (ce != 16'h0000)
              n.err = ce;
            else if (!r.en[c])
              n.warn[`ACC_WARN_SKIP] = 1'b1;
            else if (r.st == SCAN_IDLE)
            begin
              n.first = c;
              n.last = c;
              n.sets = 8'h01;
              n.async_mode = 1'b0;
              n.cur = {1'b0, c};
              n.st = SCAN_ISSUE;
            end
          `ACC_REG_SCAN:
          begin
            n.first = PWDATA[`ACC_SCAN_FIRST];
            n.last = PWDATA[`ACC_SCAN_LAST];
            n.sets = PWDATA[`ACC_SCAN_SETS];
            n.async_mode = PWDATA[`ACC_SCAN_ASYNC];
            n.st = SCAN_IDLE;
            if (PWDATA[`ACC_SCAN_ASYNC])
            begin
              n.cur = 8'h00;
              n.st = SCAN_ISSUE;
            end
            else if (PWDATA[`ACC_SCAN_FIRST] > PWDATA[`ACC_SCAN_LAST])
            begin
              n.err = `ACC_ERR_FIRST_LAST;
              n.sets = 8'h00;
            end
            else if (PWDATA[`ACC_SCAN_SETS] != 8'h00)
            begin
              n.cur = {1'b0, PWDATA[`ACC_SCAN_FIRST]};
              n.st = SCAN_ISSUE;
            end
          end
          default: ;
        endcase
      end
    end

    // Setting path: a rejected write changes only the error register
    if (do_mode || do_en || do_rng || do_flt)
    begin
      if (ce != 16'h0000)
      begin
        n.err = ce;
        bad = 1'b1;
      end
      else
      begin
        if (do_mode && wm != 16'(`ACC_MODE_SINGLE) && wm != 16'(`ACC_MODE_DIFF))
        begin
          n.err = `ACC_ERR_BAD_MODE;
          bad = 1'b1;
        end
        if (do_rng && (wr < 16'(`ACC_RANGE_10V) || wr > 16'(`ACC_RANGE_4_20)))
        begin
          n.err = `ACC_ERR_BAD_RANGE;
          bad = 1'b1;
        end
        if (do_flt && wf > `ACC_FILTER_MAX)
        begin
          n.err = `ACC_ERR_BAD_FILTER;
          bad = 1'b1;
        end
      end
      if (!bad)
      begin
        nm = do_mode ? wm[1:0] : r.mode[c];
        nr = do_rng ? wr[2:0] : r.rng[c];
        if (do_mode && !do_rng && r.mode[c] == `ACC_MODE_DIFF && nm == `ACC_MODE_SINGLE
            && is_current(r.rng[c]))
        begin
          nr = `ACC_RANGE_10V;
          n.warn[`ACC_WARN_10V] = 1'b1;
        end
        // Current range wins over a single-ended request in the same write
        if (is_current(nr) && nm == `ACC_MODE_SINGLE)
        begin
          nm = `ACC_MODE_DIFF;
          n.warn[`ACC_WARN_DIFF] = 1'b1;
        end
        n.mode[c] = nm;
        n.rng[c] = nr;
        if (do_en)
          n.en[c] = |we;
        if (do_flt)
        begin
          n.flog[c] = floor_log2(wf);
          if (wf != 16'h0000 && (wf & (wf - 16'h0001)) != 16'h0000)
            n.warn[`ACC_WARN_TRUNC] = 1'b1;
          // Any filter write restarts the average so it cannot mix lengths
          n.acc[c] = 24'h000000;
          n.cnt[c] = 8'h00;
          n.fvalid[c] = 1'b0;
        end
      end
    end

    if (RESET)
    begin
      n = '0;
      n.st = SCAN_IDLE;
      n.inst_lo = `ACC_INST_LO_RST;
      n.inst_hi = `ACC_INST_HI_RST;
      n.conv_low = 7'h01;
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        n.mode[i] = `ACC_MODE_SINGLE;
        n.rng[i] = `ACC_RANGE_10V;
        n.en[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    r <= n;
  end

  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign CONV_REQ = r.conv_req;
  assign CONV_CHAN = r.conv_chan;
  assign CONV_LOW_CHAN = r.conv_low;
  assign CONV_DIFF = r.conv_diff;
  assign CONV_RANGE = r.conv_range;
  assign READING_VALID = r.rd_valid;
  assign READING_CHAN = r.rd_chan;
  assign READING = r.rd_data;

endmodule

// file: verif/analog_channel_config_monitor.sv
`timescale 1ns/10ps
`include "analog_channel_cfg.svh"

module analog_channel_config_monitor
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic SAMPLE_VALID,
  input wire logic CONV_REQ,
  input wire logic [6:0] CONV_CHAN,
  input wire logic [6:0] CONV_LOW_CHAN,
  input wire logic CONV_DIFF,
  input wire logic [2:0] CONV_RANGE,
  input wire logic READING_VALID,
  input wire logic [15:0] READING
);
  wire st_rd = PREADY && !PWRITE && PADDR == `ACC_REG_STATUS && PRDATA != 32'h0;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  a_ready_once: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("ready not one cycle after setup");
  a_pair_low: assert property (CONV_REQ |-> CONV_LOW_CHAN == (CONV_CHAN ^ 7'h01))
    else $error("low side is not the paired channel");
  a_current_diff: assert property (CONV_REQ && CONV_RANGE > 3'h2 |-> CONV_DIFF)
    else $error("current range converted single-ended");
  a_range_code: assert property (CONV_REQ |-> CONV_RANGE inside {[3'h1:3'h4]})
    else $error("range code out of set");
  a_reading_cause: assert property (READING_VALID |-> $past(SAMPLE_VALID))
    else $error("reading without a sample");
  a_valid_pulse: assert property (READING_VALID |=> !READING_VALID)
    else $error("reading valid longer than one cycle");
  a_pct_span: assert property (READING_VALID && CONV_RANGE[2] |-> READING <= 16'h2710)
    else $error("percent reading above full span");
  // Invalid channel reads back all zero, so only a nonzero word is judged
  a_status_shape: assert property (st_rd |-> (PRDATA & 32'hff00f8ec) == 32'h0
    && $onehot(PRDATA[23:16]) && PRDATA[10:8] inside {[3'h1:3'h4]} && ^PRDATA[1:0])
    else $error("status fields out of range");

  c_diff_conv: cover property (CONV_REQ && CONV_DIFF);
  c_pct_reading: cover property (READING_VALID && CONV_RANGE == 3'h4);
  c_status_read: cover property (st_rd);
endmodule

bind analog_channel_config analog_channel_config_monitor i_mon (
  .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .SAMPLE_VALID(SAMPLE_VALID),
  .CONV_REQ(CONV_REQ), .CONV_CHAN(CONV_CHAN), .CONV_LOW_CHAN(CONV_LOW_CHAN),
  .CONV_DIFF(CONV_DIFF), .CONV_RANGE(CONV_RANGE), .READING_VALID(READING_VALID),
  .READING(READING)
);

// file: verif/analog_channel_config_bench.sv
`timescale 1ns/10ps
`include "analog_channel_cfg.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module analog_channel_config_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic samp_valid = 1'b0;
  logic [15:0] samp_data = 16'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, conv_req, conv_diff, rd_valid, err;
  logic [6:0] conv_chan, conv_low, rd_chan;
  logic [2:0] conv_range;
  logic [15:0] reading, last_raw;
  logic [6:0] conv_log[$];
  logic [6:0] exp_q[$];
  int n_fail = 0;
  int cmp_count = 0;
  int n_valid = 0;
  int lat = 0;
  int ch, m, r, e, f, hit, v0;
  int fcorner[5] = '{0, 1, 3, 128, 255};
  int bad_cfg[5] = '{32'h00010113, 32'h00010110, 32'h00010151, 32'h00010101, 32'h01000111};
  int bad_code[5] = '{32'h5e5, 32'h5e5, 32'h5e6, 32'h5e6, 32'h5e7};

  always #50 clk = ~clk;

  analog_channel_config i_dut (
    .CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SAMPLE_VALID(samp_valid), .SAMPLE_DATA(samp_data), .CONV_REQ(conv_req),
    .CONV_CHAN(conv_chan), .CONV_LOW_CHAN(conv_low), .CONV_DIFF(conv_diff),
    .CONV_RANGE(conv_range), .READING_VALID(rd_valid), .READING_CHAN(rd_chan),
    .READING(reading)
  );

  // Converter stand-in: answers each request three cycles later with a random count
  always @(posedge clk)
  begin
    samp_valid <= (lat == 1);
    if (lat == 1)
    begin
      last_raw = 16'($urandom);
      samp_data <= last_raw;
    end
    if (conv_req === 1'b1)
    begin
      conv_log.push_back(conv_chan);
      lat <= 3;
    end
    else if (lat != 0)
      lat <= lat - 1;
    if (rd_valid === 1'b1)
      n_valid++;
  end

  function automatic logic [31:0] stat(int m, int e, int r, int f);
    return 32'(f << 16 | r << 8 | int'(e != 0) << 4 | m);
  endfunction

  function automatic int flen(int v);
    int p;
    p = 1;
    while (p * 2 <= v)
      p = p * 2;
    return p;
  endfunction

  function automatic logic [15:0] pct(logic [15:0] raw);
    int x;
    x = ((int'($signed(raw)) - 1936) * 10581) >>> 13;
    if (x < 0)
      x = 0;
    if (x > 10000)
      x = 10000;
    return x[15:0];
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 20)
      n_fail++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, ex, q)
  endtask

  task automatic convert();
    int n;
    n = 0;
    v0 = n_valid;
    wr(`ACC_REG_READ, 32'h0);
    while (n_valid == v0 && n < 30)
    begin
      n++;
      @(posedge clk);
    end
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    q = 32'h02000000;
    while (q[25] === 1'b1 && n < 300)
    begin
      n++;
      apb(1'b0, `ACC_REG_SCAN, 32'h0);
    end
    `CHK("scan idle", 1'b0, q[25])
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    q = $urandom(32'hfea77a11);
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(`ACC_REG_STATUS, stat(1, 1, 1, 1), "status reset");
    chk(`ACC_REG_INST, 32'h00007f00, "inst reset");
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      ch = $urandom_range(127, 32);
      m = $urandom_range(2, 1);
      r = $urandom_range(2, 1);
      e = (i == 0) ? 0 : $urandom_range(255);
      f = (i < 5) ? fcorner[i] : $urandom_range(255);
      wr(`ACC_REG_SEL, ch);
      wr(`ACC_REG_CFG, {f[15:0], e[7:0], r[3:0], m[3:0]});
      chk(`ACC_REG_STATUS, stat(m, e, r, flen(f)), "cfg status");
      chk(`ACC_REG_WARN, {29'h0, f > 1 && f != flen(f), 2'h0}, "trunc warn");
      wr(`ACC_REG_WARN, 32'hf);
    end
    $display("test cfg done");
    wr(`ACC_REG_SEL, 32'd20);
    for (int i = 0; i < 5; i++)
    begin
      wr(`ACC_REG_CFG, bad_cfg[i]);
      chk(`ACC_REG_ERROR, bad_code[i], "param error");
      chk(`ACC_REG_STATUS, stat(1, 1, 1, 1), "not applied");
      wr(`ACC_REG_ERROR, 32'h0);
    end
    wr(`ACC_REG_FILTER, 32'd200);
    chk(`ACC_REG_STATUS, stat(1, 1, 1, 128), "filter write");
    chk(`ACC_REG_WARN, 32'h4, "filter warn");
    wr(`ACC_REG_WARN, 32'hf);
    wr(`ACC_REG_SEL, 32'd128);
    chk(`ACC_REG_STATUS, 32'h0, "bad chan status");
    chk(`ACC_REG_ERROR, `ACC_ERR_BAD_CHAN, "bad chan");
    wr(`ACC_REG_INST, 32'h00000300);
    wr(`ACC_REG_SEL, 32'd5);
    chk(`ACC_REG_STATUS, 32'h0, "absent status");
    chk(`ACC_REG_ERROR, `ACC_ERR_NOT_INSTALLED, "absent chan");
    wr(`ACC_REG_INST, 32'h00007f00);
    wr(`ACC_REG_ERROR, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, err)
    $display("test errors done");
    wr(`ACC_REG_SEL, 32'd4);
    wr(`ACC_REG_CFG, 32'h00010111);
    wr(`ACC_REG_RANGE, 32'd3);
    chk(`ACC_REG_STATUS, stat(2, 1, 3, 1), "forced diff");
    chk(`ACC_REG_WARN, 32'h1, "diff warn");
    wr(`ACC_REG_WARN, 32'hf);
    wr(`ACC_REG_MODE, 32'd1);
    chk(`ACC_REG_STATUS, stat(1, 1, 1, 1), "forced 10v");
    chk(`ACC_REG_WARN, 32'h2, "10v warn");
    wr(`ACC_REG_WARN, 32'hf);
    wr(`ACC_REG_CFG, 32'h00010141);
    chk(`ACC_REG_STATUS, stat(2, 1, 4, 1), "joint write");
    chk(`ACC_REG_WARN, 32'h1, "joint warn");
    wr(`ACC_REG_WARN, 32'hf);
    $display("test current done");
    wr(`ACC_REG_SEL, 32'd6);
    wr(`ACC_REG_CFG, 32'h00010142);
    convert();
    `CHK("even low", 7'd7, conv_low)
    `CHK("even diff", 1'b1, conv_diff)
    `CHK("percent", pct(last_raw), reading)
    `CHK("reading chan", 7'd6, rd_chan)
    `CHK("pct range", 3'd4, conv_range)
    wr(`ACC_REG_SEL, 32'd7);
    wr(`ACC_REG_CFG, 32'h00010112);
    convert();
    `CHK("odd low", 7'd6, conv_low)
    wr(`ACC_REG_SEL, 32'd6);
    wr(`ACC_REG_CFG, 32'h00040112);
    hit = n_valid;
    repeat (3) convert();
    `CHK("warmup early", 0, n_valid - hit)
    apb(1'b0, `ACC_REG_READING, 32'h0);
    `CHK("not valid", 1'b0, q[31])
    convert();
    `CHK("warmup full", 1, n_valid - hit)
    apb(1'b0, `ACC_REG_READING, 32'h0);
    `CHK("valid", 1'b1, q[31])
    $display("test convert done");
    wr(`ACC_REG_SEL, 32'd9);
    wr(`ACC_REG_ENABLE, 32'h0);
    chk(`ACC_REG_STATUS, stat(1, 0, 1, 1), "skip status");
    hit = conv_log.size();
    wr(`ACC_REG_READ, 32'h0);
    repeat (10) @(posedge clk);
    `CHK("skip no conv", hit, conv_log.size())
    chk(`ACC_REG_WARN, 32'h8, "skip warn");
    wr(`ACC_REG_SCAN, 32'h00010508);
    chk(`ACC_REG_ERROR, `ACC_ERR_FIRST_LAST, "first last");
    conv_log.delete();
    wr(`ACC_REG_SCAN, 32'h00020b08);
    wait_idle();
    for (int s = 0; s < 2; s++)
      for (int c = 8; c < 12; c++)
        if (c != 9)
          exp_q.push_back(c[6:0]);
    `CHK("scan count", 6, conv_log.size())
    for (int k = 0; k < 6; k++)
      `CHK("scan chan", exp_q[k], conv_log[k])
    conv_log.delete();
    wr(`ACC_REG_SCAN, 32'h01000000);
    repeat (400) @(posedge clk);
    wr(`ACC_REG_SCAN, 32'h0);
    wait_idle();
    hit = 0;
    foreach (conv_log[k])
      if (conv_log[k] == 7'd9)
        hit++;
    `CHK("async ran", 1'b1, conv_log.size() > 20)
    `CHK("async skip", 0, hit)
    $display("test scan done");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    wr(`ACC_REG_SEL, 32'd4);
    chk(`ACC_REG_STATUS, stat(1, 1, 1, 1), "reset again");
    $display("test reset again done");
    report_and_stop();
  end

  initial
  begin
    #3000000;
    n_fail++;
    report_and_stop();
  end
endmodule
